// ### testbench/hms_load_model.sv
// Load controller model: rail enables and straps
`timescale 1ns/1ps
`default_nettype none
module hms_load_model (
    // Clock and commands from the bench
    input wire logic clk_i,
    input wire logic want_hi_i,
    input wire logic want_lo_i,
    // Pins toward the sequencer
    output logic high_en_o = 1'b0,
    output logic low_en_o = 1'b0,
    output logic [2:0] thr_o,
    output logic [1:0] mpp_o
);
    assign thr_o = 3'h5;
    assign mpp_o = 2'h2;
    always @(posedge clk_i) begin
        high_en_o <= want_hi_i;
        low_en_o <= want_lo_i;
    end
endmodule
`default_nettype wire

// ### testbench/hms_sequencer_chk.sv
// Port-level assertion checker for the harvester mode sequencer
`timescale 1ns/1ps
`default_nettype none
module hms_sequencer_chk (
    // Clock, reset and causes
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic COLD_START_I,
    input wire logic RAILS_AT_INTERMEDIATE_I,
    input wire logic STORAGE_AT_CHARGE_READY_I,
    input wire logic STORAGE_ABOVE_OVERDISCHARGE_I,
    input wire logic HIGH_RAIL_ENABLE_I,
    input wire logic LOW_RAIL_ENABLE_I,
    // Observed outputs
    input wire logic BOOST_RAIL_RAISE_O,
    input wire logic BUCK_RAIL_RAISE_O,
    input wire logic STORAGE_PASS_SWITCH_O,
    input wire logic HIGH_RAIL_GATE_O,
    input wire logic LOW_RAIL_GATE_O,
    input wire logic REG_READY_O,
    input wire logic LOW_BATTERY_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    property p_cold_wake;
        $rose(BUCK_RAIL_RAISE_O) |-> BOOST_RAIL_RAISE_O && $past(COLD_START_I);
    endproperty
    a_cold_wake: assert property (p_cold_wake) else $error("no cold start");
    property p_wake_off;
        BOOST_RAIL_RAISE_O |-> !REG_READY_O ##1 !HIGH_RAIL_GATE_O && !LOW_RAIL_GATE_O;
    endproperty
    a_wake_off: assert property (p_wake_off) else $error("gate in wake-up");
    property p_boost_alone;
        $fell(BUCK_RAIL_RAISE_O) |-> BOOST_RAIL_RAISE_O && $past(RAILS_AT_INTERMEDIATE_I);
    endproperty
    a_boost_alone: assert property (p_boost_alone) else $error("buck early");
    property p_gates;
        HIGH_RAIL_GATE_O == $past(REG_READY_O && HIGH_RAIL_ENABLE_I)
            && LOW_RAIL_GATE_O == $past(REG_READY_O && LOW_RAIL_ENABLE_I);
    endproperty
    a_gates: assert property (p_gates) else $error("gate mismatch");
    property p_ready_cause;
        $rose(REG_READY_O) |-> $past(STORAGE_AT_CHARGE_READY_I);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("early ready");
    property p_lowbat_cause;
        $rose(LOW_BATTERY_O) |-> REG_READY_O && !$past(STORAGE_ABOVE_OVERDISCHARGE_I);
    endproperty
    a_lowbat_cause: assert property (p_lowbat_cause) else $error("early low battery");
    property p_lowbat_live;
        LOW_BATTERY_O |-> REG_READY_O && STORAGE_PASS_SWITCH_O;
    endproperty
    a_lowbat_live: assert property (p_lowbat_live) else $error("rails lost");
    property p_back_normal;
        $fell(LOW_BATTERY_O) && REG_READY_O |-> $past(STORAGE_AT_CHARGE_READY_I);
    endproperty
    a_back_normal: assert property (p_back_normal) else $error("early exit");
    property p_sleep_clear;
        $fell(REG_READY_O) |-> !LOW_BATTERY_O ##1 !STORAGE_PASS_SWITCH_O && !HIGH_RAIL_GATE_O && !LOW_RAIL_GATE_O;
    endproperty
    a_sleep_clear: assert property (p_sleep_clear) else $error("sleep outputs");
    c_ready: cover property ($rose(REG_READY_O));
    c_lowbat: cover property ($rose(LOW_BATTERY_O));
    c_sleep: cover property ($fell(REG_READY_O));
endmodule
bind hms_sequencer hms_sequencer_chk hms_sequencer_chk_inst (.*);
`default_nettype wire

// ### testbench/test_hms_sequencer.sv
// Self-checking bench for the harvester mode sequencer
`timescale 1ns/1ps
`default_nettype none
module test_hms_sequencer;
    logic clk, rst, cs, mid, bov, crdy, aov, hyst, aod, prim, want_hi, want_lo;
    logic awv, wv, bre, arv, rre, boost, buck, pass, hgate, lgate, rdy, lb, irq;
    logic awr, wrdy, bv, arr, rv, hi_en, lo_en;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [1:0] br, rr, mpp;
    logic [2:0] thr;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    hms_load_model hms_load_model_inst (.clk_i(clk), .want_hi_i(want_hi), .want_lo_i(want_lo),
        .high_en_o(hi_en), .low_en_o(lo_en), .thr_o(thr), .mpp_o(mpp));
    // Short grace time keeps the run brief
    hms_sequencer #(.GRACE_CYCLES(25'h14)) hms_sequencer_inst (.SYS_CLK_I(clk), .RESET_I(rst),
        .COLD_START_I(cs), .RAILS_AT_INTERMEDIATE_I(mid), .BOOST_AT_OVERCHARGE_I(bov),
        .STORAGE_AT_CHARGE_READY_I(crdy), .STORAGE_ABOVE_OVERCHARGE_I(aov),
        .STORAGE_BELOW_OVERCHARGE_HYST_I(hyst), .STORAGE_ABOVE_OVERDISCHARGE_I(aod),
        .BACKUP_QUARTER_ABOVE_FEEDBACK_I(prim), .HIGH_RAIL_ENABLE_I(hi_en), .LOW_RAIL_ENABLE_I(lo_en),
        .THRESHOLD_SELECT_I(thr), .MPP_RATIO_SELECT_I(mpp), .BOOST_RAIL_RAISE_O(boost),
        .BUCK_RAIL_RAISE_O(buck), .STORAGE_PASS_SWITCH_O(pass), .HIGH_RAIL_GATE_O(hgate),
        .LOW_RAIL_GATE_O(lgate), .REG_READY_O(rdy), .LOW_BATTERY_O(lb), .IRQ_O(irq),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(bre), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .S_AXI_RDATA_O(rdat),
        .S_AXI_RRESP_O(rr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er = hms_pkg::RESP_OKAY);
        logic ta, tw, done = 1'b0;
        @(posedge clk);
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bre <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = awv && awr;
            tw = wv && wrdy;
            done = bre && bv;
            if (done) chk(32'(br), 32'(er));
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (done) bre <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, logic [31:0] m, logic [31:0] e, logic [1:0] er = hms_pkg::RESP_OKAY);
        logic ta, done = 1'b0;
        @(posedge clk);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        while (!done) begin
            @(negedge clk);
            ta = arv && arr;
            done = rre && rv;
            if (done) begin
                chk(rdat & m, e);
                chk(32'(rr), 32'(er));
            end
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (done) rre <= 1'b0;
        end
    endtask
    task automatic st(input hms_pkg::hms_mode_t m, logic r, logic l);
        repeat (3) @(posedge clk);
        rd(hms_pkg::OFF_STATUS, 32'h1F, {27'h0, l, r, m});
    endtask
    // Bits: boost buck pass hgate lgate rdy lb
    task automatic pins(input logic [6:0] e);
        @(negedge clk);
        chk({25'h0, boost, buck, pass, hgate, lgate, rdy, lb}, {25'h0, e});
    endtask
    task automatic t_regs;
        rd(hms_pkg::OFF_CTRL, 32'hFF, 32'h80);
        rd(hms_pkg::OFF_IRQ_ENABLE, 32'h1F, 32'h0);
        rd(8'h40, '1, 32'h0, hms_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0, hms_pkg::RESP_SLVERR);
        wr(hms_pkg::OFF_STATUS, 32'h0, hms_pkg::RESP_SLVERR);
        rd(hms_pkg::OFF_STATUS, 32'h371F, 32'h2500);
        wr(hms_pkg::OFF_CTRL, 32'h40);
        $display("regs done");
    endtask
    task automatic t_wake;
        logic [31:0] n = 32'h0;
        @(posedge clk);
        cs <= 1'b1;
        {want_hi, want_lo} <= 2'h3;
        st(hms_pkg::HMS_WAKE_RAISE, 1'b0, 1'b0);
        pins(7'b1100000);
        @(posedge clk);
        cs <= 1'b0;
        mid <= 1'b1;
        st(hms_pkg::HMS_WAKE_BOOST, 1'b0, 1'b0);
        pins(7'b1000000);
        @(posedge clk);
        bov <= 1'b1;
        st(hms_pkg::HMS_WAKE_CHARGE, 1'b0, 1'b0);
        repeat (256) begin
            @(negedge clk);
            n += pass;
        end
        chk(n, 32'h40);
        @(posedge clk);
        crdy <= 1'b1;
        st(hms_pkg::HMS_NORMAL, 1'b1, 1'b0);
        pins(7'b0011110);
        chk(32'(irq), 32'h0);
        rd(hms_pkg::OFF_IRQ_STATUS, 32'h1F, 32'h1);
        wr(hms_pkg::OFF_IRQ_ENABLE, 32'h1F);
        pins(7'b0011110);
        chk(32'(irq), 32'h1);
        wr(hms_pkg::OFF_IRQ_CLEAR, 32'h1F);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        @(posedge clk);
        want_hi <= 1'b0;
        repeat (3) @(posedge clk);
        pins(7'b0010110);
        $display("wake done");
    endtask
    task automatic t_normal;
        @(posedge clk);
        aov <= 1'b1;
        st(hms_pkg::HMS_OVERVOLT, 1'b1, 1'b0);
        @(posedge clk);
        aov <= 1'b0;
        hyst <= 1'b1;
        st(hms_pkg::HMS_NORMAL, 1'b1, 1'b0);
        @(posedge clk);
        crdy <= 1'b0;
        aod <= 1'b0;
        prim <= 1'b1;
        st(hms_pkg::HMS_PRIMARY, 1'b1, 1'b1);
        @(posedge clk);
        crdy <= 1'b1;
        aod <= 1'b1;
        st(hms_pkg::HMS_NORMAL, 1'b1, 1'b0);
        $display("normal done");
    endtask
    task automatic t_shutdown;
        @(posedge clk);
        crdy <= 1'b0;
        aod <= 1'b0;
        prim <= 1'b0;
        want_hi <= 1'b1;
        st(hms_pkg::HMS_SHUTDOWN, 1'b1, 1'b1);
        pins(7'b0011111);
        @(posedge clk);
        crdy <= 1'b1;
        aod <= 1'b1;
        st(hms_pkg::HMS_NORMAL, 1'b1, 1'b0);
        @(posedge clk);
        crdy <= 1'b0;
        aod <= 1'b0;
        st(hms_pkg::HMS_SHUTDOWN, 1'b1, 1'b1);
        repeat (25) @(posedge clk);
        st(hms_pkg::HMS_DEEP_SLEEP, 1'b0, 1'b0);
        pins(7'b0000000);
        rd(hms_pkg::OFF_IRQ_STATUS, 32'h1F, 32'h1F);
        chk(32'(irq), 32'h1);
        $display("shutdown done");
    endtask
    task automatic t_direct;
        @(posedge clk);
        cs <= 1'b1;
        crdy <= 1'b1;
        aod <= 1'b1;
        st(hms_pkg::HMS_NORMAL, 1'b1, 1'b0);
        $display("direct done");
    endtask
    initial begin
        {rst, cs, mid, bov, crdy, aov, hyst, aod, prim} = 9'h102;
        {want_hi, want_lo, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_wake();
        t_normal();
        t_shutdown();
        t_direct();
        stop_test();
    end
endmodule
`default_nettype wire

// ### verilog/hms_grace_timer.sv
// Grace timer: counts while run is high, flags expiry at the limit
`timescale 1ns/1ps
`default_nettype none
module hms_grace_timer #(
    parameter int WIDTH = 25,
    parameter logic [WIDTH-1:0] LIMIT = 25'h1C9C380
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    output logic expired_o
);
    logic [WIDTH-1:0] count;

    // Dropping run restarts the window, so each shutdown gets a full grace time
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            count <= '0;
        end else if (count != LIMIT) begin
            count <= count + 1'b1;
        end
    end

    assign expired_o = run_i && (count == LIMIT);
endmodule
`default_nettype wire

// ### verilog/hms_pass_pwm.sv
// Pass switch modulator: fixed period, duty set by software
`timescale 1ns/1ps
`default_nettype none
module hms_pass_pwm (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic enable_i,
    input wire logic [hms_pkg::DUTY_W-1:0] duty_i,
    output logic switch_o
);
    logic [hms_pkg::DUTY_W-1:0] phase;

    always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_o <= 1'b0;
        end else begin
            switch_o <= enable_i && (phase < duty_i);
        end
    end
endmodule
`default_nettype wire

// ### verilog/hms_pkg.sv
// Shared constants and types for the harvester mode sequencer
package hms_pkg;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int READY_BIT = 3;
    localparam int LOWBAT_BIT = 4;
    localparam int THR_SEL_LSB = 8;
    localparam int THR_SEL_W = 3;
    localparam int MPP_SEL_LSB = 12;
    localparam int MPP_SEL_W = 2;
    localparam int HI_EN_BIT = 16;
    localparam int LO_EN_BIT = 17;

    // Control register: pass switch duty while charging storage
    localparam int DUTY_LSB = 0;
    localparam int DUTY_W = 8;
    localparam logic [7:0] DUTY_RST = 8'h80;

    // Interrupt events, one bit per entry into normal, overvoltage, primary, shutdown or deep sleep
    localparam int EVT_W = 5;
    localparam int EVT_NORMAL = 0;
    localparam int EVT_OVERVOLT = 1;
    localparam int EVT_PRIMARY = 2;
    localparam int EVT_SHUTDOWN = 3;
    localparam int EVT_SLEEP = 4;
    localparam logic [4:0] EVT_RST = 5'h00;

    // Grace time in shutdown before deep sleep
    localparam int GRACE_MS = 600;
    localparam int CLK_HZ = 50_000_000;
    localparam int GRACE_CYCLES = GRACE_MS * (CLK_HZ / 1000);
    localparam int GRACE_W = 25;

    typedef enum logic [2:0] {
        HMS_DEEP_SLEEP = 3'h0,
        HMS_WAKE_RAISE = 3'h1,
        HMS_WAKE_BOOST = 3'h3,
        HMS_WAKE_CHARGE = 3'h2,
        HMS_NORMAL = 3'h6,
        HMS_OVERVOLT = 3'h7,
        HMS_PRIMARY = 3'h5,
        HMS_SHUTDOWN = 3'h4
    } hms_mode_t;

endpackage

// ### verilog/hms_sequencer.sv
// Harvester mode sequencer with AXI4-Lite status and interrupt registers
//
// Operation
// - Cold-start level in deep sleep starts wake-up
// - Wake-up keeps regulators off, ready low
// - Raise both rails, then boost alone
// - Boost at overcharge, storage low: modulate switch
// - Storage charge-ready while charging enters normal
// - Storage already charged skips the charging phase
// - After ready, each rail gated by enable
// - Normal holds between overdischarge and overcharge
// - Storage above overcharge enters overvoltage mode
// - Below overdischarge: primary if available, else shutdown
// - Primary available when quarter voltage exceeds feedback
// - Primary keeps low-battery high until charge-ready
// - Shutdown raises low-battery, regulators stay enabled
// - Shutdown: recover in grace time, else sleep
`timescale 1ns/1ps
`default_nettype none
module hms_sequencer #(
    parameter logic [hms_pkg::GRACE_W-1:0] GRACE_CYCLES = hms_pkg::GRACE_W'(hms_pkg::GRACE_CYCLES)
) (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    // Comparator results
    input wire logic COLD_START_I,
    input wire logic RAILS_AT_INTERMEDIATE_I,
    input wire logic BOOST_AT_OVERCHARGE_I,
    input wire logic STORAGE_AT_CHARGE_READY_I,
    input wire logic STORAGE_ABOVE_OVERCHARGE_I,
    input wire logic STORAGE_BELOW_OVERCHARGE_HYST_I,
    input wire logic STORAGE_ABOVE_OVERDISCHARGE_I,
    input wire logic BACKUP_QUARTER_ABOVE_FEEDBACK_I,
    // System controls and straps
    input wire logic HIGH_RAIL_ENABLE_I,
    input wire logic LOW_RAIL_ENABLE_I,
    input wire logic [hms_pkg::THR_SEL_W-1:0] THRESHOLD_SELECT_I,
    input wire logic [hms_pkg::MPP_SEL_W-1:0] MPP_RATIO_SELECT_I,
    // Power stage controls
    output logic BOOST_RAIL_RAISE_O,
    output logic BUCK_RAIL_RAISE_O,
    output logic STORAGE_PASS_SWITCH_O,
    output logic HIGH_RAIL_GATE_O,
    output logic LOW_RAIL_GATE_O,
    // Status
    output logic REG_READY_O,
    output logic LOW_BATTERY_O,
    output logic IRQ_O,
    // AXI4-Lite write address and data
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [hms_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [hms_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    // AXI4-Lite write response
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    // AXI4-Lite read
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [hms_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [hms_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O
);
    hms_pkg::hms_mode_t mode;
    hms_pkg::hms_mode_t next_mode;
    logic grace_expired;
    logic backup_available;
    logic pwm_switch;
    logic [hms_pkg::DUTY_W-1:0] duty;
    logic [hms_pkg::EVT_W-1:0] irq_status;
    logic [hms_pkg::EVT_W-1:0] irq_enable;
    logic [hms_pkg::EVT_W-1:0] events;
    logic [hms_pkg::EVT_W-1:0] clear_req;
    logic aw_held;
    logic w_held;
    logic [hms_pkg::ADDR_W-1:0] aw_addr;
    logic [hms_pkg::DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [hms_pkg::DATA_W-1:0] read_word;
    logic read_hit;

    assign backup_available = BACKUP_QUARTER_ABOVE_FEEDBACK_I;

    // Mode transitions
    always_comb begin
        next_mode = mode;
        case (mode)
            hms_pkg::HMS_DEEP_SLEEP: begin
                if (COLD_START_I) begin
                    next_mode = hms_pkg::HMS_WAKE_RAISE;
                end
            end
            hms_pkg::HMS_WAKE_RAISE: begin
                if (RAILS_AT_INTERMEDIATE_I) begin
                    next_mode = hms_pkg::HMS_WAKE_BOOST;
                end
            end
            hms_pkg::HMS_WAKE_BOOST: begin
                if (BOOST_AT_OVERCHARGE_I) begin
                    if (STORAGE_AT_CHARGE_READY_I) begin
                        next_mode = hms_pkg::HMS_NORMAL;
                    end else begin
                        next_mode = hms_pkg::HMS_WAKE_CHARGE;
                    end
                end
            end
            hms_pkg::HMS_WAKE_CHARGE: begin
                if (STORAGE_AT_CHARGE_READY_I) begin
                    next_mode = hms_pkg::HMS_NORMAL;
                end
            end
            hms_pkg::HMS_NORMAL: begin
                // Overcharge is checked first; both cannot be true on a sane storage node
                if (STORAGE_ABOVE_OVERCHARGE_I) begin
                    next_mode = hms_pkg::HMS_OVERVOLT;
                end else if (!STORAGE_ABOVE_OVERDISCHARGE_I) begin
                    if (backup_available) begin
                        next_mode = hms_pkg::HMS_PRIMARY;
                    end else begin
                        next_mode = hms_pkg::HMS_SHUTDOWN;
                    end
                end
                // Otherwise stay put
            end
            hms_pkg::HMS_OVERVOLT: begin
                if (STORAGE_BELOW_OVERCHARGE_HYST_I) begin
                    next_mode = hms_pkg::HMS_NORMAL;
                end
            end
            hms_pkg::HMS_PRIMARY: begin
                if (STORAGE_AT_CHARGE_READY_I) begin
                    next_mode = hms_pkg::HMS_NORMAL;
                end
            end
            hms_pkg::HMS_SHUTDOWN: begin
                // Recovery wins if it lands in the same cycle as expiry
                if (STORAGE_AT_CHARGE_READY_I) begin
                    next_mode = hms_pkg::HMS_NORMAL;
                end else if (grace_expired) begin
                    next_mode = hms_pkg::HMS_DEEP_SLEEP;
                end
            end
            default: begin
                next_mode = hms_pkg::HMS_DEEP_SLEEP;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            mode <= hms_pkg::HMS_DEEP_SLEEP;
        end else begin
            mode <= next_mode;
        end
    end

    hms_grace_timer #(
        .WIDTH(hms_pkg::GRACE_W),
        .LIMIT(GRACE_CYCLES)
    ) u_grace (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .run_i(mode == hms_pkg::HMS_SHUTDOWN),
        .expired_o(grace_expired)
    );

    // Status outputs follow the next mode so they change with the mode register
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            REG_READY_O <= 1'b0;
            LOW_BATTERY_O <= 1'b0;
        end else begin
            case (next_mode)
                hms_pkg::HMS_NORMAL, hms_pkg::HMS_OVERVOLT: begin
                    REG_READY_O <= 1'b1;
                    LOW_BATTERY_O <= 1'b0;
                end
                hms_pkg::HMS_PRIMARY: begin
                    REG_READY_O <= 1'b1;
                    LOW_BATTERY_O <= 1'b1;
                end
                hms_pkg::HMS_SHUTDOWN: begin
                    REG_READY_O <= 1'b1;
                    LOW_BATTERY_O <= 1'b1;
                end
                default: begin
                    REG_READY_O <= 1'b0;
                    LOW_BATTERY_O <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            BOOST_RAIL_RAISE_O <= 1'b0;
            BUCK_RAIL_RAISE_O <= 1'b0;
        end else begin
            BOOST_RAIL_RAISE_O <= (next_mode == hms_pkg::HMS_WAKE_RAISE) ||
                                  (next_mode == hms_pkg::HMS_WAKE_BOOST);
            BUCK_RAIL_RAISE_O <= (next_mode == hms_pkg::HMS_WAKE_RAISE);
        end
    end

    // Regulator gates: the ready flag already folds in every mode restriction
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            HIGH_RAIL_GATE_O <= 1'b0;
            LOW_RAIL_GATE_O <= 1'b0;
        end else begin
            HIGH_RAIL_GATE_O <= REG_READY_O && HIGH_RAIL_ENABLE_I;
            LOW_RAIL_GATE_O <= REG_READY_O && LOW_RAIL_ENABLE_I;
        end
    end

    hms_pass_pwm u_pwm (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .enable_i(mode == hms_pkg::HMS_WAKE_CHARGE),
        .duty_i(duty),
        .switch_o(pwm_switch)
    );

    // Storage stays disconnected in deep sleep and early wake-up
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            STORAGE_PASS_SWITCH_O <= 1'b0;
        end else begin
            case (mode)
                hms_pkg::HMS_WAKE_CHARGE: STORAGE_PASS_SWITCH_O <= pwm_switch;
                hms_pkg::HMS_NORMAL, hms_pkg::HMS_OVERVOLT,
                hms_pkg::HMS_PRIMARY, hms_pkg::HMS_SHUTDOWN: STORAGE_PASS_SWITCH_O <= 1'b1;
                default: STORAGE_PASS_SWITCH_O <= 1'b0;
            endcase
        end
    end

    // Mode entry events
    always_comb begin
        events = '0;
        if (next_mode != mode) begin
            events[hms_pkg::EVT_NORMAL] = (next_mode == hms_pkg::HMS_NORMAL);
            events[hms_pkg::EVT_OVERVOLT] = (next_mode == hms_pkg::HMS_OVERVOLT);
            events[hms_pkg::EVT_PRIMARY] = (next_mode == hms_pkg::HMS_PRIMARY);
            events[hms_pkg::EVT_SHUTDOWN] = (next_mode == hms_pkg::HMS_SHUTDOWN);
            events[hms_pkg::EVT_SLEEP] = (next_mode == hms_pkg::HMS_DEEP_SLEEP);
        end
    end

    assign clear_req = (do_write && aw_addr == hms_pkg::OFF_IRQ_CLEAR && w_strb[0]) ?
                       w_data[hms_pkg::EVT_W-1:0] : '0;

    // An event in the clearing cycle survives the clear
    for (genvar i = 0; i < hms_pkg::EVT_W; i++) begin : g_irq
        always_ff @(posedge SYS_CLK_I) begin
            if (RESET_I) begin
                irq_status[i] <= 1'b0;
            end else if (events[i]) begin
                irq_status[i] <= 1'b1;
            end else if (clear_req[i]) begin
                irq_status[i] <= 1'b0;
            end
        end
    end

    assign IRQ_O = |(irq_status & irq_enable);

    // Write channel: address and data may arrive in either order
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR_I;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA_I;
            w_strb <= S_AXI_WSTRB_I;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O = !w_held && !S_AXI_BVALID_O;
    assign do_write = aw_held && w_held && !S_AXI_BVALID_O;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            duty <= hms_pkg::DUTY_RST;
            irq_enable <= hms_pkg::EVT_RST;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == hms_pkg::OFF_CTRL) begin
                duty <= w_data[hms_pkg::DUTY_LSB +: hms_pkg::DUTY_W];
            end
            if (aw_addr == hms_pkg::OFF_IRQ_ENABLE) begin
                irq_enable <= w_data[hms_pkg::EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= hms_pkg::RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID_O <= 1'b1;
            case (aw_addr)
                hms_pkg::OFF_CTRL, hms_pkg::OFF_IRQ_CLEAR,
                hms_pkg::OFF_IRQ_ENABLE: S_AXI_BRESP_O <= hms_pkg::RESP_OKAY;
                default: S_AXI_BRESP_O <= hms_pkg::RESP_SLVERR;
            endcase
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // Read decode; straps are shown so software can confirm the board setup
    always_comb begin
        read_word = '0;
        read_hit = 1'b1;
        case (S_AXI_ARADDR_I)
            hms_pkg::OFF_STATUS: begin
                read_word[hms_pkg::MODE_LSB +: hms_pkg::MODE_W] = mode;
                read_word[hms_pkg::READY_BIT] = REG_READY_O;
                read_word[hms_pkg::LOWBAT_BIT] = LOW_BATTERY_O;
                read_word[hms_pkg::THR_SEL_LSB +: hms_pkg::THR_SEL_W] = THRESHOLD_SELECT_I;
                read_word[hms_pkg::MPP_SEL_LSB +: hms_pkg::MPP_SEL_W] = MPP_RATIO_SELECT_I;
                read_word[hms_pkg::HI_EN_BIT] = HIGH_RAIL_ENABLE_I;
                read_word[hms_pkg::LO_EN_BIT] = LOW_RAIL_ENABLE_I;
            end
            hms_pkg::OFF_CTRL: read_word[hms_pkg::DUTY_LSB +: hms_pkg::DUTY_W] = duty;
            hms_pkg::OFF_IRQ_STATUS: read_word[hms_pkg::EVT_W-1:0] = irq_status;
            hms_pkg::OFF_IRQ_ENABLE: read_word[hms_pkg::EVT_W-1:0] = irq_enable;
            hms_pkg::OFF_IRQ_CLEAR: read_word = '0;
            default: read_hit = 1'b0;
        endcase
    end

    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= hms_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O <= read_word;
            S_AXI_RRESP_O <= read_hit ? hms_pkg::RESP_OKAY : hms_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
        end
    end
endmodule
`default_nettype wire
